// >>> core/lmc_classifier.v
// Notes on behaviour
// - Step reference through thresholds; support test levels
// - Four states: wire open, open, closed, short
// - Three thresholds writable, defaults 20/12/4 V
// - Same thresholds apply without monitor device fitted
// - Report on/off word and line-health word
// - Point one in bit zero, sixteen MSB
// - Health bit set healthy, cleared on open/short
// - Line faults raise no module fault output
// - Health bits follow line, never latch
// - Mask suppresses indicator only, monitoring continues
// - Masked indicator off; unhealthy unmasked indicator on
// - Status derived from three operating comparator readings
// - Contact indicator lit when closed or shorted
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "lmc_map.vh"

module lmc_classifier (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    // Comparator results from the field side, high when input above ref
    input  wire [15:0] cmp_above,
    // Reference level for the field DAC, signed tenths of a volt
    output reg  [15:0] ref_code_r,
    // Packed status words
    output reg  [15:0] in_status_r,
    output reg  [15:0] line_ok_r,
    // Front panel indicators
    output reg  [15:0] contact_led_r,
    output reg  [15:0] fault_led_r,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ==========================================================
    // Constants
    // ==========================================================
    localparam [2:0]  ST_IDLE   = 3'b001;         // Waiting for scan enable
    localparam [2:0]  ST_SETTLE = 3'b010;         // Reference settling
    localparam [2:0]  ST_SAMPLE = 3'b100;         // Capture comparators
    localparam [2:0]  LV_OPEN   = 3'd0;           // Open circuit level
    localparam [2:0]  LV_ONOFF  = 3'd1;           // On/off level
    localparam [2:0]  LV_SHORT  = 3'd2;           // Short circuit level
    localparam [2:0]  LV_TON    = 3'd3;           // Stuck-on test level
    localparam [2:0]  LV_TOFF   = 3'd4;           // Stuck-off test level
    localparam [11:0] SETTLE_CYC = `LMC_SETTLE_CYC;

    // ==========================================================
    // State
    // ==========================================================
    reg  [15:0] sync1_r;                          // Synchroniser stage 1
    reg  [15:0] sync2_r;                          // Synchroniser stage 2
    reg  [15:0] sync3_r;                          // Synchroniser stage 3
    reg  [15:0] cmp_r;                            // Filtered comparator bits
    reg  [1:0]  ctrl_r;                           // Scan enable, test request
    reg  [15:0] thr_open_r;                       // Open threshold
    reg  [15:0] thr_onoff_r;                      // On/off threshold
    reg  [15:0] thr_short_r;                      // Short threshold
    reg  [15:0] mask_r;                           // Fault indicator mask
    reg  [15:0] test_on_r;                        // Readings at stuck-on level
    reg  [15:0] test_off_r;                       // Readings at stuck-off level
    reg         valid_r;                          // A full set was committed
    reg         tdone_r;                          // Sticky test-cycle done
    reg  [2:0]  state_r;                          // Sequencer state
    reg  [2:0]  lvl_r;                            // Current reference level
    reg  [11:0] cnt_r;                            // Settle counter
    reg  [15:0] rd_open_r;                        // Reading at open level
    reg  [15:0] rd_onoff_r;                       // Reading at on/off level
    reg         test_run_r;                       // Test levels in this pass
    reg  [7:0]  awaddr_r;                         // Held write address
    reg  [31:0] wdata_r;                          // Held write data
    reg  [3:0]  wstrb_r;                          // Held write strobes
    reg         aw_got_r;                         // Write address taken
    reg         w_got_r;                          // Write data taken

    wire [15:0] healthy;                          // Between short and open
    wire [15:0] closed;                           // Below on/off threshold
    wire        do_write;                         // Both halves of write held
    wire        tdone_set;                        // Test pass finishing
    wire        end_set;                          // Operating set finishing

    // ==========================================================
    // Byte-lane merge for writable words
    // ==========================================================
    function [15:0] lmc_merge;
        input [15:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer i;
        begin
            lmc_merge = old_v;
            for (i = 0; i < 2; i = i + 1) begin
                if (strb[i]) begin
                    lmc_merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    // ==========================================================
    // Comparator input synchronisers, one per point
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_pt
            // Stage 1 is read only by stage 2; bit counts once 2 and 3 agree
            always @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                    sync3_r[g] <= 1'b0;
                    cmp_r[g]   <= 1'b0;
                end else if (ce) begin
                    sync1_r[g] <= cmp_above[g];
                    sync2_r[g] <= sync1_r[g];
                    sync3_r[g] <= sync2_r[g];
                    if (sync2_r[g] == sync3_r[g]) begin
                        cmp_r[g] <= sync3_r[g];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Classification from the three operating readings
    // ==========================================================
    // Healthy only above short and not above open; same with or
    // without a monitor device, which simply reads open or short
    assign healthy = cmp_r & ~rd_open_r;          // cmp_r holds short reading here
    assign closed  = ~rd_onoff_r;                 // Below on/off means closed
    assign end_set = (state_r == ST_SAMPLE) && (lvl_r == LV_SHORT);
    assign tdone_set = (state_r == ST_SAMPLE) && (lvl_r == LV_TOFF);

    // ==========================================================
    // Reference sequencer
    // ==========================================================
    // Steps open, on/off, short, then optionally the two test levels.
    // Settling covers DAC slew and the synchroniser depth.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= ST_IDLE;
            lvl_r       <= LV_OPEN;
            cnt_r       <= 12'h000;
            ref_code_r  <= `LMC_RST_THR_OPEN;
            rd_open_r   <= 16'h0000;
            rd_onoff_r  <= 16'h0000;
            test_on_r   <= 16'h0000;
            test_off_r  <= 16'h0000;
            test_run_r  <= 1'b0;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    // Start a pass at the open level
                    if (ctrl_r[`LMC_CTRL_SCAN_EN]) begin
                        lvl_r      <= LV_OPEN;
                        ref_code_r <= thr_open_r;
                        cnt_r      <= SETTLE_CYC;
                        test_run_r <= ctrl_r[`LMC_CTRL_TEST];
                        state_r    <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    // Wait for reference and inputs to settle
                    if (cnt_r <= 12'h001) begin
                        state_r <= ST_SAMPLE;
                    end else begin
                        cnt_r <= cnt_r - 12'h001;
                    end
                end
                ST_SAMPLE: begin
                    // Capture and pick the next level
                    cnt_r   <= SETTLE_CYC;
                    state_r <= ST_SETTLE;
                    case (lvl_r)
                        LV_OPEN: begin
                            rd_open_r  <= cmp_r;
                            lvl_r      <= LV_ONOFF;
                            ref_code_r <= thr_onoff_r;
                        end
                        LV_ONOFF: begin
                            rd_onoff_r <= cmp_r;
                            lvl_r      <= LV_SHORT;
                            ref_code_r <= thr_short_r;
                        end
                        LV_SHORT: begin
                            if (test_run_r) begin
                                lvl_r      <= LV_TON;
                                ref_code_r <= `LMC_REF_STUCK_ON;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                        LV_TON: begin
                            test_on_r  <= cmp_r;
                            lvl_r      <= LV_TOFF;
                            ref_code_r <= `LMC_REF_STUCK_OFF;
                        end
                        LV_TOFF: begin
                            test_off_r <= cmp_r;
                            state_r    <= ST_IDLE;
                        end
                        default: begin
                            state_r <= ST_IDLE;
                        end
                    endcase
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Status words and indicators
    // ==========================================================
    // Commit only at the end of a full operating set, so on/off and
    // health always come from the same pass. No latching: each pass
    // overwrites. Faults go nowhere but these bits.
    always @(posedge aclk) begin
        if (!aresetn) begin
            in_status_r   <= 16'h0000;
            line_ok_r     <= 16'h0000;
            contact_led_r <= 16'h0000;
            fault_led_r   <= 16'h0000;
            valid_r       <= 1'b0;
        end else if (ce) begin
            if (end_set) begin
                in_status_r   <= closed;                   // Bit 0 is point one
                line_ok_r     <= healthy;                  // Set while healthy
                contact_led_r <= closed;                   // Closed or shorted
                valid_r       <= 1'b1;
            end
            // Mask gates only the lamp; health bit unaffected
            fault_led_r <= ~(end_set ? healthy : line_ok_r) & ~mask_r;
        end
    end

    // ==========================================================
    // AXI4-Lite write channel
    // ==========================================================
    assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

    // Address and data taken in either order; response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LMC_RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            ctrl_r        <= `LMC_RST_CTRL;
            thr_open_r    <= `LMC_RST_THR_OPEN;
            thr_onoff_r   <= `LMC_RST_THR_ONOFF;
            thr_short_r   <= `LMC_RST_THR_SHORT;
            mask_r        <= `LMC_RST_MASK;
            tdone_r       <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r      <= s_axi_awaddr;
                aw_got_r      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // Test request clears itself once the pass has picked it up
            if ((state_r == ST_IDLE) && ctrl_r[`LMC_CTRL_SCAN_EN]) begin
                ctrl_r[`LMC_CTRL_TEST] <= 1'b0;
            end
            // Sticky test done; set below overrides a clear
            if (do_write) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `LMC_RESP_OKAY;
                case (awaddr_r[7:2])
                    `LMC_A_CTRL >> 2: begin
                        if (wstrb_r[0]) begin
                            ctrl_r <= wdata_r[1:0];
                        end
                    end
                    `LMC_A_THR_OPEN >> 2: begin
                        thr_open_r <= lmc_merge(thr_open_r, wdata_r, wstrb_r);
                    end
                    `LMC_A_THR_ONOFF >> 2: begin
                        thr_onoff_r <= lmc_merge(thr_onoff_r, wdata_r, wstrb_r);
                    end
                    `LMC_A_THR_SHORT >> 2: begin
                        thr_short_r <= lmc_merge(thr_short_r, wdata_r, wstrb_r);
                    end
                    `LMC_A_FI_MASK >> 2: begin
                        mask_r <= lmc_merge(mask_r, wdata_r, wstrb_r);
                    end
                    `LMC_A_STAT >> 2: begin
                        if (wstrb_r[0] && wdata_r[`LMC_STAT_TDONE]) begin
                            tdone_r <= 1'b0;
                        end
                    end
                    // Read-only words accept and ignore the write
                    `LMC_A_IN_STATUS >> 2, `LMC_A_LINE_OK >> 2,
                    `LMC_A_TEST_ON >> 2, `LMC_A_TEST_OFF >> 2: begin
                        s_axi_bresp <= `LMC_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `LMC_RESP_SLVERR;
                    end
                endcase
            end
            if (tdone_set) begin
                tdone_r <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    // ==========================================================
    // Status words read as sign-extended 16-bit integers
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `LMC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `LMC_RESP_OKAY;
                case (s_axi_araddr[7:2])
                    `LMC_A_CTRL >> 2:      s_axi_rdata <= {30'h00000000, ctrl_r};
                    `LMC_A_THR_OPEN >> 2:  s_axi_rdata <= {16'h0000, thr_open_r};
                    `LMC_A_THR_ONOFF >> 2: s_axi_rdata <= {16'h0000, thr_onoff_r};
                    `LMC_A_THR_SHORT >> 2: s_axi_rdata <= {16'h0000, thr_short_r};
                    `LMC_A_FI_MASK >> 2:   s_axi_rdata <= {16'h0000, mask_r};
                    `LMC_A_IN_STATUS >> 2: s_axi_rdata <= {{16{in_status_r[15]}},
                                                           in_status_r};
                    `LMC_A_LINE_OK >> 2:   s_axi_rdata <= {{16{line_ok_r[15]}},
                                                           line_ok_r};
                    `LMC_A_TEST_ON >> 2:   s_axi_rdata <= {16'h0000, test_on_r};
                    `LMC_A_TEST_OFF >> 2:  s_axi_rdata <= {16'h0000, test_off_r};
                    `LMC_A_STAT >> 2:      s_axi_rdata <= {29'h00000000, tdone_r,
                                                           valid_r,
                                                           (state_r != ST_IDLE)};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `LMC_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // lmc_classifier

// >>> core/lmc_map.vh
`ifndef LMC_MAP_VH
`define LMC_MAP_VH

// ==========================================================
// Register byte offsets (AXI4-Lite, one word each)
// ==========================================================
`define LMC_A_CTRL       8'h00
`define LMC_A_THR_OPEN   8'h04
`define LMC_A_THR_ONOFF  8'h08
`define LMC_A_THR_SHORT  8'h0c
`define LMC_A_FI_MASK    8'h10
`define LMC_A_IN_STATUS  8'h14
`define LMC_A_LINE_OK    8'h18
`define LMC_A_TEST_ON    8'h1c
`define LMC_A_TEST_OFF   8'h20
`define LMC_A_STAT       8'h24

// ==========================================================
// Field positions
// ==========================================================
`define LMC_CTRL_SCAN_EN 0
`define LMC_CTRL_TEST    1
`define LMC_STAT_BUSY    0
`define LMC_STAT_VALID   1
`define LMC_STAT_TDONE   2

// ==========================================================
// Reference levels, signed tenths of a volt; control and mask reset values
// ==========================================================
`define LMC_RST_THR_OPEN  16'h00c8
`define LMC_RST_THR_ONOFF 16'h0078
`define LMC_RST_THR_SHORT 16'h0028
`define LMC_REF_STUCK_ON  16'h0140
`define LMC_REF_STUCK_OFF 16'hffce
`define LMC_RST_CTRL      2'h1
`define LMC_RST_MASK      16'h0000

// ==========================================================
// Timing
// ==========================================================
`define LMC_CLK_NS        10
`define LMC_SETTLE_NS     1000
`define LMC_SETTLE_CYC    ((`LMC_SETTLE_NS + `LMC_CLK_NS - 1) / `LMC_CLK_NS)

// ==========================================================
// Bus responses
// ==========================================================
`define LMC_RESP_OKAY     2'h0
`define LMC_RESP_SLVERR   2'h2

`endif

// >>> sim/lmc_classifier_test.sv
`timescale 1ns/1ns
`include "lmc_map.vh"
// ==========================================================
// Self-checking bench
// ==========================================================
module lmc_classifier_test;
    localparam logic signed [15:0] T_OPEN = `LMC_RST_THR_OPEN;
    localparam logic signed [15:0] T_SHORT = `LMC_RST_THR_SHORT;
    logic aclk = 0, aresetn = 0, ce = 1;
    logic [15:0] ref_code_r, in_status_r, line_ok_r, contact_led_r, fault_led_r, cmp_above;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic signed [15:0] vin [16];
    int n_errors = 0, n_tests = 0;
    always #5 aclk = ~aclk;
    lmc_classifier u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .cmp_above(cmp_above),
        .ref_code_r(ref_code_r), .in_status_r(in_status_r), .line_ok_r(line_ok_r),
        .contact_led_r(contact_led_r), .fault_led_r(fault_led_r),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    lmc_field_model u_fld (.ref_code(ref_code_r), .vin(vin), .cmp_above(cmp_above));
    // Expected word, sign-extended: closed (h=0) or healthy (h=1)
    function automatic [31:0] exp_w(input bit h, input logic signed [15:0] onoff);
        logic [15:0] w;
        for (int i = 0; i < 16; i++)
            w[i] = h ? (vin[i] > T_SHORT && !(vin[i] > T_OPEN)) : !(vin[i] > onoff);
        return {{16{w[15]}}, w};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ready is read at the falling edge; it holds to the next rising one
    task axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk) {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'b11};
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk) {awvalid, wvalid} <= 2'b00;
        do @(negedge aclk); while (bvalid !== 1'b1);
        @(posedge aclk) bready <= 1'b1; // Late ready: response must stand
        @(posedge aclk) bready <= 1'b0;
    endtask
    task axi_rd(input logic [7:0] a);
        @(posedge aclk) {araddr, arvalid} <= {a, 1'b1};
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk) arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        @(posedge aclk) rready <= 1'b1;
        @(posedge aclk) {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    // Apply a four-level pattern, wait out two whole passes
    task set_v(input int v0, input int v1, input int v2, input int v3);
        int p [4];
        p = '{v0, v1, v2, v3};
        @(posedge aclk) for (int i = 0; i < 16; i++) vin[i] <= 16'(p[i % 4]);
        repeat (1100) @(posedge aclk);
    endtask
    task t_defaults;
        axi_rd(`LMC_A_THR_OPEN); chk(d, 32'h000000c8);
        axi_rd(`LMC_A_THR_ONOFF); chk(d, 32'h00000078);
        axi_rd(`LMC_A_THR_SHORT); chk(d, 32'h00000028);
        axi_rd(8'h40); chk({30'h0, r}, {30'h0, `LMC_RESP_SLVERR});
        $display("t_defaults done");
    endtask
    // Wire open, switch open, switch closed, wire short
    task t_classify;
        set_v(240, 160, 80, 0);
        axi_rd(`LMC_A_IN_STATUS); chk(d, exp_w(0, 16'sh0078));
        axi_rd(`LMC_A_LINE_OK); chk(d, exp_w(1, 16'sh0078));
        chk({{16{contact_led_r[15]}}, contact_led_r}, exp_w(0, 16'sh0078));
        chk({16'h0, fault_led_r}, ~exp_w(1, 16'sh0078) & 32'hffff);
        $display("t_classify done");
    endtask
    task t_mask;
        axi_wr(`LMC_A_FI_MASK, 32'h000000ff);
        repeat (4) @(posedge aclk);
        chk({16'h0, fault_led_r}, ~exp_w(1, 16'sh0078) & 32'hff00);
        axi_rd(`LMC_A_LINE_OK); chk(d, exp_w(1, 16'sh0078));
        $display("t_mask done");
    endtask
    task t_recover;
        set_v(160, 160, 160, 160);
        axi_rd(`LMC_A_LINE_OK); chk(d, 32'hffffffff);
        chk({16'h0, fault_led_r}, 32'h0);
        $display("t_recover done");
    endtask
    task t_test_levels;
        axi_wr(`LMC_A_CTRL, 32'h00000003);
        set_v(160, 160, 160, 160);
        axi_rd(`LMC_A_STAT); chk({31'h0, d[`LMC_STAT_TDONE]}, 32'h1);
        axi_rd(`LMC_A_TEST_ON); chk({16'h0, d[15:0]}, 32'h0);
        axi_rd(`LMC_A_TEST_OFF); chk({16'h0, d[15:0]}, 32'h0000ffff);
        $display("t_test_levels done");
    endtask
    task t_thresh;
        axi_wr(`LMC_A_THR_ONOFF, 32'h000000aa);
        axi_rd(`LMC_A_THR_ONOFF); chk(d, 32'h000000aa);
        set_v(160, 160, 160, 160);
        axi_rd(`LMC_A_IN_STATUS); chk(d, exp_w(0, 16'sh00aa));
        $display("t_thresh done");
    endtask
    task final_report;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog: four 1100-cycle waits plus bus traffic
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        final_report;
    end
    initial begin
        for (int i = 0; i < 16; i++) vin[i] = 16'sd160;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_defaults; t_classify; t_mask; t_recover; t_test_levels; t_thresh;
        final_report;
    end
endmodule // lmc_classifier_test

// >>> sim/lmc_field_model.sv
`timescale 1ns/1ns
// ==========================================================
// Field comparators, one per point
// ==========================================================
module lmc_field_model (
    input wire logic signed [15:0] ref_code,
    input logic signed [15:0]      vin [16],
    output logic [15:0]            cmp_above
);
    // Ideal comparator; the sequencer covers settling
    always_comb for (int i = 0; i < 16; i++) cmp_above[i] = vin[i] > $signed(ref_code);
endmodule // lmc_field_model

// >>> sim/lmc_monitor.sv
`timescale 1ns/1ns
`include "lmc_map.vh"
// ==========================================================
// Port checker for the classifier
// ==========================================================
module lmc_monitor (
    input logic        aclk,
    input logic        aresetn,
    input logic [15:0] ref_code_r,
    input logic [15:0] in_status_r,
    input logic [15:0] line_ok_r,
    input logic [15:0] contact_led_r,
    input logic [15:0] fault_led_r,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both write channels taken on one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Response offered but not yet accepted
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open while response pending");
    a_b_stands: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not on time");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data changed while pending");
    a_contact_same: assert property (contact_led_r == in_status_r)
        else $error("contact indicator differs from switch word");
    a_fault_led_off: assert property ((fault_led_r & line_ok_r) == 16'h0000)
        else $error("fault indicator lit on a healthy line");
    // Words may only move right after the last operating reading
    a_words_commit: assert property (($changed(in_status_r) || $changed(line_ok_r))
        |-> $past(ref_code_r) == `LMC_RST_THR_SHORT)
        else $error("status words moved mid pass");
endmodule // lmc_monitor

bind lmc_classifier lmc_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .ref_code_r(ref_code_r), .in_status_r(in_status_r), .line_ok_r(line_ok_r),
    .contact_led_r(contact_led_r), .fault_led_r(fault_led_r),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
